// file: pkg/rwc_pkg.sv
// Package of constants and carrier types for the reception watch and cycle block
package rwc_pkg;
  // Register byte offsets
  localparam logic [11:0] RWC_OFS_CTRL = 12'h000;
  localparam logic [11:0] RWC_OFS_STATUS = 12'h004;
  localparam logic [11:0] RWC_OFS_MASK = 12'h008;
  localparam logic [11:0] RWC_OFS_CYCLE = 12'h00c;
  localparam logic [11:0] RWC_OFS_PTN_EVT = 12'h010;
  localparam logic [11:0] RWC_OFS_SV_TMO = 12'h014;
  localparam logic [11:0] RWC_OFS_CHAN_ERR = 12'h018;
  localparam logic [11:0] RWC_OFS_BITS = 12'h01c;
  localparam logic [11:0] RWC_OFS_NUM_BASE = 12'h040;
  localparam logic [11:0] RWC_OFS_CH_BASE = 12'h080;
  // Channel config word fields
  localparam int RWC_CH_EN_BIT = 31;
  localparam int RWC_CH_KIND_BIT = 30;
  localparam int RWC_CH_IDX_LSB = 16;
  localparam int RWC_CH_TMO_LSB = 0;
  // Reset values
  localparam logic [15:0] RWC_TMO_RESET = 16'h00b4;
  localparam logic [15:0] RWC_CYCLE_RESET = 16'h00c8;
  localparam logic [15:0] RWC_SV_TMO_RESET = 16'h000a;
  // Cycle period limits in ms
  localparam logic [15:0] RWC_CYC_100 = 16'h0064;
  localparam logic [15:0] RWC_CYC_200 = 16'h00c8;
  localparam logic [15:0] RWC_CYC_400 = 16'h0190;
  // Time base
  localparam int RWC_CLK_MHZ = 250;
  localparam int RWC_MS_NS = 1000000;
  localparam int RWC_MS_CYCLES = RWC_MS_NS * RWC_CLK_MHZ / 1000;
  // Status bits
  localparam int RWC_ST_RECV = 0;
  localparam int RWC_ST_PTN = 1;
  localparam int RWC_ST_SV = 2;
  localparam int RWC_ST_W = 3;
  // Channel config carrier
  typedef struct packed {
    logic en;
    logic kind;
    logic [4:0] idx;
    logic [15:0] tmo;
  } rwc_chan_type;
  // Write strobe carrier for watched variables
  typedef struct packed {
    logic bit_wr;
    logic [4:0] bit_idx;
    logic num_wr;
    logic [3:0] num_idx;
  } rwc_wr_type;
endpackage

// file: rtl/rwc_chan.sv
// One reception watch channel: elapsed time against timeout
`timescale 1ns/1ps
module rwc_chan (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Setup and events
  input wire rwc_pkg::rwc_chan_type cfg,
  input wire rwc_pkg::rwc_wr_type wr,
  input wire logic tick,
  // Result
  output logic err
);
  import rwc_pkg::*;
  typedef struct packed {
    logic [15:0] cnt;
    logic err;
  } rwc_cs_type;
  rwc_cs_type st_q, st_d;
  logic hit;
  // Target written by communications
  always_comb begin
    hit = cfg.kind ? (wr.num_wr && wr.num_idx == cfg.idx[3:0]) : (wr.bit_wr && wr.bit_idx == cfg.idx);
  end
  // Elapsed time and error level
  always_comb begin
    st_d = st_q;
    if (!cfg.en) begin
      st_d.cnt = '0;
      st_d.err = 1'b0;
    end else if (hit) begin
      st_d.cnt = '0;
    end else if (tick && !st_q.err) begin
      // Only a full timeout of whole seconds raises the error, never early
      if (st_q.cnt >= cfg.tmo) begin
        st_d.err = 1'b1;
      end else begin
        st_d.cnt = st_q.cnt + 16'h0001;
      end
    end
    if (hit) begin
      st_d.err = 1'b0;
    end
  end
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end
  assign err = st_q.err;
  // Error never stands on a disabled channel
  property p_dis_clear;
    @(posedge clk) disable iff (rst) !cfg.en |=> !err;
  endproperty
  a_dis_clear: assert property (p_dis_clear) else $error("error on disabled channel");
  // A write clears the error next cycle
  property p_hit_clear;
    @(posedge clk) disable iff (rst) (cfg.en && hit) |=> !err && st_q.cnt == 16'h0000;
  endproperty
  a_hit_clear: assert property (p_hit_clear) else $error("write did not restart channel");
endmodule // rwc_chan

// file: rtl/rwc_top.sv
// Reception watch, partner/supervisor timeouts and cycle period with APB registers
`timescale 1ns/1ps
module rwc_top #(
  parameter int NCH = 16,
  parameter int NBITS = 32,
  parameter int NNUM = 16,
  parameter int MS_CYCLES = rwc_pkg::RWC_MS_CYCLES,
  parameter logic [15:0] CYCLE_DEFAULT = rwc_pkg::RWC_CYCLE_RESET,
  parameter logic [15:0] SV_TMO_DEFAULT = rwc_pkg::RWC_SV_TMO_RESET
) (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // APB slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  // Peer transfer and supervisor events
  input wire logic partner_no_response,
  input wire logic partner_error,
  input wire logic supervisor_ack,
  // Results
  output logic cycle_tick,
  output logic [NCH-1:0] reception_error,
  output logic reception_summary_error,
  output logic partner_transfer_timeout_alarm,
  output logic supervisor_timeout,
  output logic irq
);
  import rwc_pkg::*;
  typedef struct packed {
    logic [NCH-1:0][22:0] chan;
    logic [NNUM-1:0][15:0] num;
    logic [NBITS-1:0] bits;
    logic [15:0] cycle;
    logic [15:0] sv_tmo;
    logic [RWC_ST_W-1:0] status;
    logic [RWC_ST_W-1:0] mask;
    logic [31:0] ms_cnt;
    logic [15:0] cyc_cnt;
    logic [15:0] sec_cnt;
    logic [15:0] sv_cnt;
    logic ptn;
    logic svto;
    logic [31:0] rdata;
    logic tick;
  } rwc_state_type;
  rwc_state_type s_q, s_d;
  rwc_wr_type wr;
  logic [NCH-1:0] ch_err;
  logic wr_acc, rd_acc, sec_tick, ms_tick, any_err;
  logic [15:0] cyc_eff;
  logic [RWC_ST_W-1:0] ev;
  logic [11:0] woff;

  // APB writes in access phase, reads in setup phase, zero wait
  assign wr_acc = psel && penable && pwrite;
  assign rd_acc = psel && !penable && !pwrite;
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign woff = {paddr[11:2], 2'b00};

  // Effective cycle period: round up to 100, 200 or 400, anything above 400 gives 400
  always_comb begin
    if (s_q.cycle <= RWC_CYC_100) begin
      cyc_eff = RWC_CYC_100;
    end else if (s_q.cycle <= RWC_CYC_200) begin
      cyc_eff = RWC_CYC_200;
    end else begin
      cyc_eff = RWC_CYC_400;
    end
  end

  // Write strobes into watched variables
  always_comb begin
    wr = '0;
    if (wr_acc && woff == RWC_OFS_BITS) begin
      wr.bit_wr = 1'b1;
    end
    if (wr_acc && woff >= RWC_OFS_NUM_BASE && woff < RWC_OFS_CH_BASE) begin
      wr.num_wr = 1'b1;
      wr.num_idx = paddr[5:2];
    end
  end

  // Channel configurations and watchers
  genvar g;
  generate
    for (g = 0; g < NCH; g++) begin : g_ch
      rwc_chan_type c;
      rwc_wr_type w;
      assign c = rwc_chan_type'(s_q.chan[g]);
      // Single-bit writes: each changed bit counts as written
      assign w = '{bit_wr: wr.bit_wr && !c.kind && pwdata[c.idx] != s_q.bits[c.idx], bit_idx: c.idx,
        num_wr: wr.num_wr, num_idx: wr.num_idx};
      rwc_chan u_chan (
        .clk(clk),
        .rst(rst),
        .cfg(c),
        .wr(w),
        .tick(sec_tick),
        .err(ch_err[g])
      );
    end
  endgenerate

  assign ms_tick = s_q.ms_cnt == 32'(MS_CYCLES - 1);
  assign sec_tick = s_q.tick && (s_q.sec_cnt == 16'd0);
  assign any_err = |ch_err;

  // Next state: registers, timebase, alarms
  always_comb begin
    s_d = s_q;
    s_d.tick = 1'b0;
    ev = '0;
    s_d.ms_cnt = ms_tick ? 32'd0 : s_q.ms_cnt + 32'd1;
    if (ms_tick) begin
      if (s_q.cyc_cnt + 16'd1 >= cyc_eff) begin
        s_d.cyc_cnt = 16'd0;
        s_d.tick = 1'b1;
      end else begin
        s_d.cyc_cnt = s_q.cyc_cnt + 16'd1;
      end
    end
    // Seconds accumulate in ms of cycle periods
    if (s_q.tick) begin
      s_d.sec_cnt = (s_q.sec_cnt + cyc_eff >= 16'd1000) ? 16'd0 : s_q.sec_cnt + cyc_eff;
    end
    // Partner trouble is flagged only, nothing stops
    s_d.ptn = partner_no_response || partner_error;
    ev[RWC_ST_PTN] = s_d.ptn && !s_q.ptn;
    // Supervisor acknowledge timer in cycle periods
    if (supervisor_ack) begin
      s_d.sv_cnt = 16'd0;
      s_d.svto = 1'b0;
    end else if (s_q.tick && !s_q.svto) begin
      if (s_q.sv_cnt + 16'd1 >= s_q.sv_tmo) begin
        s_d.svto = 1'b1;
      end else begin
        s_d.sv_cnt = s_q.sv_cnt + 16'd1;
      end
    end
    ev[RWC_ST_SV] = s_d.svto && !s_q.svto;
    ev[RWC_ST_RECV] = any_err;
    // Register writes
    if (wr_acc) begin
      case (woff)
        RWC_OFS_STATUS: s_d.status = s_q.status & ~pwdata[RWC_ST_W-1:0];
        RWC_OFS_MASK: s_d.mask = pwdata[RWC_ST_W-1:0];
        RWC_OFS_CYCLE: s_d.cycle = pwdata[15:0];
        RWC_OFS_SV_TMO: s_d.sv_tmo = pwdata[15:0];
        RWC_OFS_BITS: s_d.bits = pwdata[NBITS-1:0];
        default: begin
        end
      endcase
      if (woff >= RWC_OFS_NUM_BASE && woff < RWC_OFS_CH_BASE) begin
        s_d.num[paddr[5:2]] = pwdata[15:0];
      end
      if (woff >= RWC_OFS_CH_BASE && woff < RWC_OFS_CH_BASE + 12'h040) begin
        s_d.chan[paddr[5:2]] = {pwdata[RWC_CH_EN_BIT], pwdata[RWC_CH_KIND_BIT],
          pwdata[RWC_CH_IDX_LSB+4:RWC_CH_IDX_LSB], pwdata[RWC_CH_TMO_LSB+15:RWC_CH_TMO_LSB]};
      end
    end
    // Set wins over clear
    s_d.status = s_d.status | ev;
    // Read data in setup phase
    s_d.rdata = 32'h0000_0000;
    if (rd_acc) begin
      case (woff)
        RWC_OFS_CTRL: s_d.rdata = {31'h0, any_err};
        RWC_OFS_STATUS: s_d.rdata = {29'h0, s_q.status};
        RWC_OFS_MASK: s_d.rdata = {29'h0, s_q.mask};
        RWC_OFS_CYCLE: s_d.rdata = {16'h0, cyc_eff};
        RWC_OFS_PTN_EVT: s_d.rdata = {31'h0, s_q.ptn};
        RWC_OFS_SV_TMO: s_d.rdata = {15'h0, s_q.svto, s_q.sv_tmo};
        RWC_OFS_CHAN_ERR: s_d.rdata = {16'h0, ch_err};
        RWC_OFS_BITS: s_d.rdata = s_q.bits;
        default: begin
          if (woff >= RWC_OFS_NUM_BASE && woff < RWC_OFS_CH_BASE) begin
            s_d.rdata = {16'h0, s_q.num[paddr[5:2]]};
          end else if (woff >= RWC_OFS_CH_BASE && woff < RWC_OFS_CH_BASE + 12'h040) begin
            s_d.rdata = {s_q.chan[paddr[5:2]][22], s_q.chan[paddr[5:2]][21], 9'h0,
              s_q.chan[paddr[5:2]][20:16], s_q.chan[paddr[5:2]][15:0]};
          end
        end
      endcase
    end
  end

  // State register with reset defaults
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s_q <= '0;
      for (int i = 0; i < NCH; i++) begin
        s_q.chan[i] <= {1'b0, 1'b0, 5'h00, RWC_TMO_RESET};
      end
      s_q.cycle <= CYCLE_DEFAULT;
      s_q.sv_tmo <= SV_TMO_DEFAULT;
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs
  assign prdata = s_q.rdata;
  assign cycle_tick = s_q.tick;
  assign reception_error = ch_err;
  assign reception_summary_error = any_err;
  assign partner_transfer_timeout_alarm = s_q.ptn;
  assign supervisor_timeout = s_q.svto;
  assign irq = |(s_q.status & s_q.mask);

  // Summary follows channel errors
  property p_summary;
    @(posedge clk) disable iff (rst) reception_summary_error == (|reception_error);
  endproperty
  a_summary: assert property (p_summary) else $error("summary bit mismatch");
  // Partner trouble shows one cycle later
  property p_ptn;
    @(posedge clk) disable iff (rst) (partner_no_response || partner_error) |=> partner_transfer_timeout_alarm;
  endproperty
  a_ptn: assert property (p_ptn) else $error("partner alarm missing");
  // Ack clears supervisor timeout
  property p_svack;
    @(posedge clk) disable iff (rst) supervisor_ack |=> !supervisor_timeout;
  endproperty
  a_svack: assert property (p_svack) else $error("supervisor flag not cleared");
  // Timebase keeps running whatever the partner does
  property p_run;
    @(posedge clk) disable iff (rst) partner_transfer_timeout_alarm |=> s_q.ms_cnt != $past(s_q.ms_cnt);
  endproperty
  a_run: assert property (p_run) else $error("timebase halted");
  // Effective period always in the list
  property p_cyc;
    @(posedge clk) disable iff (rst) cyc_eff == RWC_CYC_100 || cyc_eff == RWC_CYC_200 || cyc_eff == RWC_CYC_400;
  endproperty
  a_cyc: assert property (p_cyc) else $error("cycle period off list");
  // Rounding of 101..200
  property p_round;
    @(posedge clk) disable iff (rst) (s_q.cycle > RWC_CYC_100 && s_q.cycle <= RWC_CYC_200) |-> cyc_eff == RWC_CYC_200;
  endproperty
  a_round: assert property (p_round) else $error("round up failed");
  // Bit write is stored
  property p_bits;
    @(posedge clk) disable iff (rst) (wr_acc && woff == RWC_OFS_BITS) |=> s_q.bits == $past(pwdata);
  endproperty
  a_bits: assert property (p_bits) else $error("bit variables not stored");
  // Status set on channel error
  property p_stat;
    @(posedge clk) disable iff (rst) any_err |=> s_q.status[RWC_ST_RECV];
  endproperty
  a_stat: assert property (p_stat) else $error("status not set");
  // Alarm drops once the trouble inputs are quiet
  property p_ptn_low;
    @(posedge clk) disable iff (rst) !(partner_no_response || partner_error) |=> !partner_transfer_timeout_alarm;
  endproperty
  a_ptn_low: assert property (p_ptn_low) else $error("partner alarm stuck");
  // Alarm onset latches its status bit
  property p_ptn_evt;
    @(posedge clk) disable iff (rst) $rose(partner_transfer_timeout_alarm) |-> s_q.status[RWC_ST_PTN];
  endproperty
  a_ptn_evt: assert property (p_ptn_evt) else $error("partner status not set");
  // Supervisor timeout latches its status bit
  property p_sv_evt;
    @(posedge clk) disable iff (rst) $rose(supervisor_timeout) |-> s_q.status[RWC_ST_SV];
  endproperty
  a_sv_evt: assert property (p_sv_evt) else $error("supervisor status not set");
  // Supervisor flag holds until acknowledged
  property p_sv_hold;
    @(posedge clk) disable iff (rst) (supervisor_timeout && !supervisor_ack) |=> supervisor_timeout;
  endproperty
  a_sv_hold: assert property (p_sv_hold) else $error("supervisor flag dropped");
  // Acknowledge restarts the supervisor timer
  property p_sv_restart;
    @(posedge clk) disable iff (rst) supervisor_ack |=> s_q.sv_cnt == 16'h0000;
  endproperty
  a_sv_restart: assert property (p_sv_restart) else $error("supervisor timer not restarted");
  // Rounding of values above 200
  property p_round400;
    @(posedge clk) disable iff (rst) (s_q.cycle > RWC_CYC_200) |-> cyc_eff == RWC_CYC_400;
  endproperty
  a_round400: assert property (p_round400) else $error("round up to 400 failed");
  // Cycle tick lasts one clock
  property p_tick;
    @(posedge clk) disable iff (rst) cycle_tick |=> !cycle_tick;
  endproperty
  a_tick: assert property (p_tick) else $error("cycle tick too long");
  // Numeric variable write is stored
  property p_num;
    @(posedge clk) disable iff (rst) wr.num_wr |=> s_q.num[$past(wr.num_idx)] == $past(pwdata[15:0]);
  endproperty
  a_num: assert property (p_num) else $error("numeric variable not stored");
  // Numeric variable reads back zero extended
  property p_num_rd;
    @(posedge clk) disable iff (rst) (rd_acc && woff >= RWC_OFS_NUM_BASE && woff < RWC_OFS_CH_BASE)
      |=> prdata == {16'h0000, $past(s_q.num[paddr[5:2]])};
  endproperty
  a_num_rd: assert property (p_num_rd) else $error("numeric read wrong");
  // Bit variables read back as stored
  property p_bits_rd;
    @(posedge clk) disable iff (rst) (rd_acc && woff == RWC_OFS_BITS) |=> prdata == $past(s_q.bits);
  endproperty
  a_bits_rd: assert property (p_bits_rd) else $error("bit variables read wrong");
  // Channel timeout field lands
  property p_chan_tmo;
    @(posedge clk) disable iff (rst) (wr_acc && woff >= RWC_OFS_CH_BASE && woff < RWC_OFS_CH_BASE + 12'h040)
      |=> s_q.chan[$past(paddr[5:2])][15:0] == $past(pwdata[15:0]);
  endproperty
  a_chan_tmo: assert property (p_chan_tmo) else $error("channel timeout not stored");
  // Channel enable field lands
  property p_chan_en;
    @(posedge clk) disable iff (rst) (wr_acc && woff >= RWC_OFS_CH_BASE && woff < RWC_OFS_CH_BASE + 12'h040)
      |=> s_q.chan[$past(paddr[5:2])][22] == $past(pwdata[RWC_CH_EN_BIT]);
  endproperty
  a_chan_en: assert property (p_chan_en) else $error("channel enable not stored");
  // Places beyond the sixteen channels read zero
  property p_unmapped;
    @(posedge clk) disable iff (rst) (rd_acc && woff >= RWC_OFS_CH_BASE + 12'h040) |=> prdata == 32'h0000_0000;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // Receive status stays until cleared by a one
  property p_stat_hold;
    @(posedge clk) disable iff (rst)
      (s_q.status[RWC_ST_RECV] && !(wr_acc && woff == RWC_OFS_STATUS && pwdata[RWC_ST_RECV])) |=> s_q.status[RWC_ST_RECV];
  endproperty
  a_stat_hold: assert property (p_stat_hold) else $error("receive status lost");
  // Mask write is stored
  property p_mask;
    @(posedge clk) disable iff (rst) (wr_acc && woff == RWC_OFS_MASK) |=> s_q.mask == $past(pwdata[RWC_ST_W-1:0]);
  endproperty
  a_mask: assert property (p_mask) else $error("mask not stored");
endmodule // rwc_top

// file: bench/rwc_peer_model.sv
// Peer module and supervisor stand-in driving the trouble and acknowledge inputs
`timescale 1ns/1ps
module rwc_peer_model (
  // Clock and reset
  input wire logic clk,
  input wire logic rst,
  // Bench controls
  input wire logic [1:0] trouble_mode,
  input wire logic ack_en,
  input wire logic cycle_tick,
  // Toward the block
  output logic partner_no_response,
  output logic partner_error,
  output logic supervisor_ack
);
  // Trouble levels change only after an edge; supervisor acks once per cycle tick
  // Stands in for the configured sending peer, quiet until reset ends
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      partner_no_response <= 1'b0;
      partner_error <= 1'b0;
      supervisor_ack <= 1'b0;
    end else begin
      partner_no_response <= trouble_mode == 2'h1;
      partner_error <= trouble_mode == 2'h2;
      supervisor_ack <= ack_en && cycle_tick;
    end
  end
endmodule // rwc_peer_model

// file: bench/reception_watch_and_cycle_tb_top.sv
// Self-checking testbench for the reception watch and cycle block
`timescale 1ns/1ps
module reception_watch_and_cycle_tb_top;
  import rwc_pkg::*;
  logic clk = 1'b0, rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, ack_en = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h00000000, rd;
  logic [1:0] trouble_mode = 2'h0;
  logic [31:0] prdata;
  logic pready, pslverr, pnr, perr, sack, cycle_tick, rsum, alarm, svto, irq;
  logic [15:0] rerr;
  int bad_count = 0, compares = 0, n;
  // Cycle write values and the effective period expected back
  logic [15:0] cyc_in [5] = '{16'h0064, 16'h0096, 16'h00c8, 16'h00c9, 16'h0190};
  logic [15:0] cyc_ex [5] = '{16'h0064, 16'h00c8, 16'h00c8, 16'h0190, 16'h0190};

  rwc_top #(.MS_CYCLES(4)) rwc_top_inst (.clk(clk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .partner_no_response(pnr), .partner_error(perr), .supervisor_ack(sack),
    .cycle_tick(cycle_tick), .reception_error(rerr), .reception_summary_error(rsum),
    .partner_transfer_timeout_alarm(alarm), .supervisor_timeout(svto), .irq(irq));
  rwc_peer_model rwc_peer_model_inst (.clk(clk), .rst(rst), .trouble_mode(trouble_mode),
    .ack_en(ack_en), .cycle_tick(cycle_tick), .partner_no_response(pnr), .partner_error(perr),
    .supervisor_ack(sack));

  // Clock
  initial begin
    forever #2 clk = ~clk;
  end

  task conclude;
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer: setup, then access until pready sampled high
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int k;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    for (k = 0; k < 50; k++) begin
      @(posedge clk);
      if (pready === 1'b1) break;
    end
    if (k == 50) begin
      bad_count++;
      conclude();
    end
    rd = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // Bounded wait on a chosen output; n returns the cycles spent
  task wait_hi(input int sel, input int lim);
    logic s;
    for (n = 1; n <= lim; n++) begin
      @(posedge clk);
      s = sel == 0 ? rerr[0] : sel == 1 ? svto : sel == 2 ? cycle_tick : rerr[1];
      if (s === 1'b1) break;
    end
    if (n > lim) begin
      bad_count++;
      conclude();
    end
  endtask

  initial begin
    repeat (2) @(posedge clk);
    rst <= 1'b0;
    // Reset values and an unmapped place
    apb(0, RWC_OFS_CH_BASE, 0); chk(rd, 32'h000000b4);
    apb(0, RWC_OFS_CYCLE, 0); chk(rd, 32'h000000c8);
    apb(0, RWC_OFS_SV_TMO, 0); chk(rd, 32'h0000000a);
    apb(1, 12'hffc, 32'h12345678); apb(0, 12'hffc, 0); chk(rd, 32'h00000000);
    chk(pslverr, 1'b0); chk(pready, 1'b1);
    // Cycle period rounding, ending at 100 ms
    for (int i = 0; i < 5; i++) begin
      apb(1, RWC_OFS_CYCLE, {16'h0000, cyc_in[i]});
      apb(0, RWC_OFS_CYCLE, 0); chk(rd, {16'h0000, cyc_ex[i]});
    end
    apb(1, RWC_OFS_CYCLE, 32'h00000064);
    wait_hi(2, 2000); wait_hi(2, 2000); chk(n, 400);
    // Shared variables read back
    apb(1, RWC_OFS_BITS, 32'ha5c3e10f); apb(0, RWC_OFS_BITS, 0); chk(rd, 32'ha5c3e10f);
    apb(1, RWC_OFS_NUM_BASE + 12'h03c, 32'h0000beef);
    apb(0, RWC_OFS_NUM_BASE + 12'h03c, 0); chk(rd, 32'h0000beef);
    // Two channels: numeric 3 and bit 7, one second each, kept alive then left to lapse
    apb(1, RWC_OFS_CH_BASE, 32'hc0030001);
    apb(1, RWC_OFS_CH_BASE + 12'h004, 32'h80070001);
    for (int i = 0; i < 3; i++) begin
      repeat (1600) @(posedge clk);
      apb(1, RWC_OFS_NUM_BASE + 12'h00c, i);
      apb(1, RWC_OFS_BITS, {24'ha5c3e1, ~i[0], 7'h0f});
      chk(rerr, 16'h0000);
    end
    wait_hi(0, 9000); chk(n >= 3990 && n <= 8000, 1);
    wait_hi(3, 4100);
    chk(rerr, 16'h0003); chk(rsum, 1'b1); chk(irq, 1'b0);
    apb(0, RWC_OFS_CHAN_ERR, 0); chk(rd, 32'h00000003);
    apb(0, RWC_OFS_CTRL, 0); chk(rd, 32'h00000001);
    apb(1, RWC_OFS_MASK, 32'h00000007); @(posedge clk); chk(irq, 1'b1);
    apb(1, RWC_OFS_CH_BASE, 32'h40030001); apb(1, RWC_OFS_CH_BASE + 12'h004, 0);
    apb(1, RWC_OFS_STATUS, 32'h00000001); apb(0, RWC_OFS_STATUS, 0);
    chk(rd & 32'h1, 32'h0); chk(rerr, 16'h0000); chk(irq, 1'b0);
    // Partner trouble of both kinds at 400 ms; the block keeps cycling
    apb(1, RWC_OFS_CYCLE, 32'h00000190);
    for (int m = 1; m < 3; m++) begin
      trouble_mode <= 2'(m);
      repeat (3) @(posedge clk);
      chk(alarm, 1'b1); apb(0, RWC_OFS_PTN_EVT, 0); chk(rd, 32'h00000001);
      wait_hi(2, 2000);
    end
    trouble_mode <= 2'h0;
    repeat (3) @(posedge clk);
    chk(alarm, 1'b0); apb(0, RWC_OFS_STATUS, 0); chk(rd & 32'h2, 32'h2);
    // Peer transfer dropped: period back to 100 ms, let it settle
    apb(1, RWC_OFS_CYCLE, 32'h00000064); apb(0, RWC_OFS_CYCLE, 0); chk(rd, 32'h00000064);
    wait_hi(2, 2000); wait_hi(2, 2000);
    // Supervisor stops acknowledging, only once peer transfer is off
    ack_en <= 1'b0;
    wait_hi(1, 6000); chk(n >= 3600 && n <= 4002, 1);
    apb(0, RWC_OFS_SV_TMO, 0); chk(rd, 32'h0001000a);
    apb(0, RWC_OFS_STATUS, 0); chk(rd & 32'h4, 32'h4); chk(irq, 1'b1);
    conclude();
  end
endmodule // reception_watch_and_cycle_tb_top
